// ### design/dvio_top.sv
// Digital I/O port block: bus slave, ports, flags and interrupter.
`timescale 1ns/1ps
module dvio_top #(
	// Arbitrary identification text, eight ASCII characters
	parameter logic [63:0] ID_TEXT = 64'h4449_4749_4F50_4F52
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [dvio_pkg::ADDR_W-1:0] addr_i,
	input wire logic [dvio_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [dvio_pkg::DATA_W-1:0] rd_data_o,
	input wire logic iack_i,
	input wire logic [dvio_pkg::LVL_W-1:0] iack_level_i,
	input wire logic [dvio_pkg::BASE_W-1:0] base_sel_i,
	input wire logic [dvio_pkg::LVL_W-1:0] irq_level_sel_i,
	input wire logic [dvio_pkg::NIRQ-1:0] edge_sel_i,
	input wire logic [dvio_pkg::NIRQ-1:0] irq_line_i,
	input wire logic [63:0] port_in_i,
	output logic [63:0] port_out_o,
	output logic [63:0] port_oe_o,
	output logic [dvio_pkg::NFLAG-1:0] flag_o,
	output logic irq_o,
	output logic [dvio_pkg::LVL_W-1:0] irq_level_o
);
	import dvio_pkg::*;

	typedef struct packed {
		logic [63:0] pin1;
		logic [63:0] pin2;
		logic [5:0] base1;
		logic [5:0] base2;
		logic [2:0] lvl1;
		logic [2:0] lvl2;
		logic [2:0] lvl3;
		logic ie;
		logic [7:0] dir;
		logic [63:0] pout;
		logic [7:0] mask;
		logic [7:0] vec;
		logic [7:0] flag;
		logic [15:0] rdata;
		logic irq;
	} dvio_top_st_t;

	dvio_top_st_t st_reg;
	dvio_top_st_t st_next;
	dvio_irq_if irq_bus ();
	logic hit;
	logic [9:0] off;
	logic [7:0] active;

	////////////////////////////////////////////////////////////////////////
	// Interrupt latch
	dvio_irq_latch u_latch (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.irq(irq_bus)
	);

	assign irq_bus.line = irq_line_i;
	assign irq_bus.edge_sel = edge_sel_i;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Word of a port pair: output ports read their latch, inputs the pins
	function automatic logic [15:0] port_word(input logic [1:0] idx,
		input logic [7:0] dir, input logic [63:0] pout, input logic [63:0] pin);
		logic [15:0] w;
		logic [4:0] b;
		w = DATA_ZERO;
		for (int h = 0; h < 2; h++) begin
			b = {idx, 1'b0} + 5'(h);
			if (dir[b[2:0]]) begin
				w[h*8 +: 8] = pout[b[2:0]*8 +: 8];
			end else begin
				w[h*8 +: 8] = pin[b[2:0]*8 +: 8];
			end
		end
		return w;
	endfunction : port_word

	////////////////////////////////////////////////////////////////////////
	// Address decode
	// base on a one-kilobyte boundary
	assign hit = (addr_i[ADDR_W-1:OFF_W] == st_reg.base2);
	assign off = addr_i[OFF_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Next state: synchronisers, register writes, read mux
	always_comb begin
		st_next = st_reg;
		irq_bus.clr = 8'h00;
		irq_bus.soft_rst = 1'b0;
		// Pins and switches pass two flops before use
		st_next.pin1 = port_in_i;
		st_next.pin2 = st_reg.pin1;
		st_next.base1 = base_sel_i;
		st_next.base2 = st_reg.base1;
		st_next.lvl1 = irq_level_sel_i;
		st_next.lvl2 = st_reg.lvl1;
		// Level output trails one flop so it moves together with the request
		st_next.lvl3 = st_reg.lvl2;

		if (wr_en_i && hit) begin
			unique case (off)
				OFF_CTRL: begin
					if (wr_data_i[CTRL_SRST_BIT]) begin
						irq_bus.soft_rst = 1'b1;
						st_next.ie = 1'b0;
						st_next.dir = DIR_RST;
						st_next.pout = PORT_RST;
						st_next.mask = MASK_RST;
						st_next.vec = VEC_RST;
						st_next.flag = FLAG_RST;
					end else begin
						st_next.ie = wr_data_i[CTRL_IE_BIT];
					end
				end
				OFF_DIR: st_next.dir = wr_data_i[7:0];
				OFF_CLR: irq_bus.clr = wr_data_i[7:0];
				OFF_MASK: st_next.mask = wr_data_i[7:0];
				OFF_VEC: st_next.vec = wr_data_i[7:0];
				OFF_FLAG: st_next.flag = wr_data_i[7:0];
				default: begin
					// port data, two ports per word
					if (off >= OFF_PORT0 && off <= OFF_PORT3 && !off[0]) begin
						st_next.pout[off[2:1]*16 +: 16] = wr_data_i;
					end
				end
			endcase
		end

		// Read data stands one cycle after the strobe, zero otherwise
		st_next.rdata = DATA_ZERO;
		if (iack_i) begin
			// vector on acknowledge at own level
			if (iack_level_i == st_reg.lvl3 && st_reg.irq) begin
				st_next.rdata = {8'h00, st_reg.vec};
			end
		end else if (rd_en_i && hit) begin
			unique case (off)
				OFF_CTRL: st_next.rdata = {14'h0000, 1'b0, st_reg.ie};
				OFF_DIR: st_next.rdata = {8'h00, st_reg.dir};
				OFF_IRQIN: st_next.rdata = {8'h00, irq_bus.level};
				OFF_PEND: st_next.rdata = {8'h00, irq_bus.pending};
				OFF_MASK: st_next.rdata = {8'h00, st_reg.mask};
				OFF_VEC: st_next.rdata = {8'h00, st_reg.vec};
				OFF_FLAG: st_next.rdata = {8'h00, st_reg.flag};
				default: begin
					if (off >= OFF_ID0 && off <= OFF_ID3 && !off[0]) begin
						st_next.rdata = ID_TEXT[(3 - off[2:1])*16 +: 16];
					end else if (off >= OFF_PORT0 && off <= OFF_PORT3 && !off[0]) begin
						st_next.rdata = port_word(off[2:1], st_reg.dir, st_reg.pout,
							st_reg.pin2);
					end
				end
			endcase
		end

		active = irq_bus.pending & ~st_reg.mask;
		// request only while enabled and unmasked pending
		st_next.irq = st_next.ie && (|active) && (st_reg.lvl2 != 3'h0);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '{pin1: '0, pin2: '0, base1: '0, base2: '0, lvl1: '0, lvl2: '0,
				lvl3: '0, ie: 1'b0, dir: DIR_RST, pout: PORT_RST, mask: MASK_RST, vec: VEC_RST,
				flag: FLAG_RST, rdata: DATA_ZERO, irq: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	// eight byte ports, enables follow direction
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			port_oe_o[p*8 +: 8] = {8{st_reg.dir[p]}};
		end
	end

	assign port_out_o = st_reg.pout;
	assign flag_o = st_reg.flag;
	assign rd_data_o = st_reg.rdata;
	assign irq_o = st_reg.irq;
	assign irq_level_o = st_reg.lvl3;

endmodule : dvio_top

// ### design/dvio_pkg.sv
// Constants and types shared by the digital I/O port block.
//
// Contract
// - Sixty-four channels form eight independent byte-wide ports, each usable in either direction.
// - One bit per port in the port direction register sets that port alone to input or output.
// - Each of the eight interrupt inputs latches on a rising or falling edge chosen per line by a static setting.
// - A mask register masks each interrupt line on its own so that a masked line raises no request.
// - Writing a one to a bit of the interrupt clear register clears that latched interrupt, zeros change nothing.
// - A readable pending register shows which latched interrupts still await service.
// - A software-written vector register is returned to the bus master in the interrupt acknowledge cycle.
// - The bus interrupt request is raised on one level from one to seven chosen by a three-bit static switch.
// - Eight software-controlled flag outputs serve external equipment as acknowledge or control lines.
// - The status/control register holds an interrupt enable bit and a soft reset bit restoring the defaults.
// - The block decodes a one-kilobyte window of short I/O space whose base sits on any of 64 boundaries.
// - The block acts as a 16-bit data slave, taking and producing all slave-side control, address and data.
// - Read-only ASCII identification data stands at fixed locations inside the block.
package dvio_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	localparam int OFF_W = 10;
	localparam int BASE_W = 6;
	localparam int NPORT = 8;
	localparam int NIRQ = 8;
	localparam int NFLAG = 8;
	localparam int LVL_W = 3;

	// Byte offsets inside the one-kilobyte window
	localparam logic [9:0] OFF_ID0 = 10'h000;
	localparam logic [9:0] OFF_ID3 = 10'h006;
	localparam logic [9:0] OFF_CTRL = 10'h080;
	localparam logic [9:0] OFF_PORT0 = 10'h100;
	localparam logic [9:0] OFF_PORT3 = 10'h106;
	localparam logic [9:0] OFF_DIR = 10'h110;
	localparam logic [9:0] OFF_IRQIN = 10'h120;
	localparam logic [9:0] OFF_CLR = 10'h122;
	localparam logic [9:0] OFF_MASK = 10'h124;
	localparam logic [9:0] OFF_PEND = 10'h126;
	localparam logic [9:0] OFF_VEC = 10'h128;
	localparam logic [9:0] OFF_FLAG = 10'h12A;

	// Control register fields
	localparam int CTRL_IE_BIT = 0;
	localparam int CTRL_SRST_BIT = 1;

	// Reset values
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [7:0] VEC_RST = 8'h0F;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [63:0] PORT_RST = 64'h0000_0000_0000_0000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	typedef logic [DATA_W-1:0] dvio_word_t;

endpackage : dvio_pkg

// ### design/dvio_irq_if.sv
// Interface between the register logic and the interrupt latch.
`timescale 1ns/1ps
interface dvio_irq_if;
	logic [7:0] line;
	logic [7:0] edge_sel;
	logic [7:0] clr;
	logic soft_rst;
	logic [7:0] pending;
	logic [7:0] level;

	modport regs (output line, output edge_sel, output clr, output soft_rst,
		input pending, input level);
	modport latch (input line, input edge_sel, input clr, input soft_rst,
		output pending, output level);
endinterface : dvio_irq_if

// ### design/dvio_irq_latch.sv
// Edge-latched interrupt inputs with per-line edge select and clear.
`timescale 1ns/1ps
module dvio_irq_latch (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	dvio_irq_if.latch irq
);
	import dvio_pkg::*;

	typedef struct packed {
		logic [7:0] ln1;
		logic [7:0] ln2;
		logic [7:0] prev;
		logic [7:0] es1;
		logic [7:0] es2;
		logic [7:0] pend;
		logic [1:0] warm;
	} dvio_latch_st_t;

	dvio_latch_st_t st_reg;
	dvio_latch_st_t st_next;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] ev;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.ln1 = irq.line;
		st_next.ln2 = st_reg.ln1;
		st_next.prev = st_reg.ln2;
		st_next.es1 = irq.edge_sel;
		st_next.es2 = st_reg.es1;
		rise = st_reg.ln2 & ~st_reg.prev;
		fall = ~st_reg.ln2 & st_reg.prev;
		// Hold off edges until the sync and compare flops hold real samples
		if (st_reg.warm != 2'h3) begin
			st_next.warm = st_reg.warm + 2'h1;
		end
		ev = (st_reg.warm == 2'h3) ? ((st_reg.es2 & rise) | (~st_reg.es2 & fall)) : 8'h00;
		if (irq.soft_rst) begin
			st_next.pend = ev;
		end else begin
			st_next.pend = (st_reg.pend & ~irq.clr) | ev;
		end
	end

	// Async reset to constants only
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign irq.pending = st_reg.pend;
	assign irq.level = st_reg.ln2;

endmodule : dvio_irq_latch

// ### tb/dvio_top_sva.sv
// Assertions on the pins of the digital I/O port block.
`timescale 1ns/1ps
module dvio_top_sva (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [15:0] rd_data_o,
	input wire logic iack_i,
	input wire logic [5:0] base_sel_i,
	input wire logic [2:0] irq_level_sel_i,
	input wire logic [7:0] irq_line_i,
	input wire logic [63:0] port_out_o,
	input wire logic [63:0] port_oe_o,
	input wire logic [7:0] flag_o,
	input wire logic irq_o,
	input wire logic [2:0] irq_level_o
);
	import dvio_pkg::*;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	logic hit;
	logic [9:0] off;
	logic [63:0] oe_exp;
	// Write decode; base switch is static so the raw pins do
	assign hit = wr_en_i && addr_i[15:10] == base_sel_i;
	assign off = addr_i[9:0];
	// Each enable byte copies one direction bit
	always_comb begin
		for (int b = 0; b < 64; b++) oe_exp[b] = wr_data_i[b / 8];
	end
	// Lines quiet long enough that no late edge can re-arm
	sequence s_quiet; $stable(irq_line_i) [*4]; endsequence
	sequence s_clr_all; hit && off == OFF_CLR && wr_data_i[7:0] == 8'hFF; endsequence
	property p_clr; s_quiet ##0 s_clr_all |=> ##1 !irq_o; endproperty
	a_clr: assert property (p_clr) else $error("request held after clear");
	property p_oe; hit && off == OFF_DIR |=> port_oe_o == $past(oe_exp); endproperty
	a_oe: assert property (p_oe) else $error("enable mismatch");
	property p_port; hit && off == OFF_PORT0 |=> port_out_o[15:0] == $past(wr_data_i); endproperty
	a_port: assert property (p_port) else $error("port latch mismatch");
	property p_flag; hit && off == OFF_FLAG |=> flag_o == $past(wr_data_i[7:0]); endproperty
	a_flag: assert property (p_flag) else $error("flag mismatch");
	property p_idle; !$past(rd_en_i) && !$past(iack_i) |-> rd_data_o == DATA_ZERO; endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	property p_lvl; $stable(irq_level_sel_i) [*5] |-> irq_level_o == irq_level_sel_i; endproperty
	a_lvl: assert property (p_lvl) else $error("level mismatch");
	property p_lvl0; irq_o |-> irq_level_o != 3'h0; endproperty
	a_lvl0: assert property (p_lvl0) else $error("request on level zero");
	property p_off; hit && (off == OFF_CTRL && !wr_data_i[CTRL_IE_BIT]
		|| off == OFF_MASK && wr_data_i[7:0] == 8'hFF) |-> ##2 !irq_o; endproperty
	a_off: assert property (p_off) else $error("request while blocked");
endmodule : dvio_top_sva
bind dvio_top dvio_top_sva chk_i (.core_clk_i, .resetn_i, .addr_i, .wr_data_i, .wr_en_i,
	.rd_en_i, .rd_data_o, .iack_i, .base_sel_i, .irq_level_sel_i, .irq_line_i, .port_out_o,
	.port_oe_o, .flag_o, .irq_o, .irq_level_o);

// ### tb/dvio_host.sv
// Host bus master model for the register port.
`timescale 1ns/1ps
module dvio_host (
	input wire logic core_clk_i,
	input wire logic [15:0] rd_data_i,
	output logic [15:0] addr_o,
	output logic [15:0] wr_data_o,
	output logic wr_en_o,
	output logic rd_en_o,
	output logic iack_o,
	output logic [2:0] iack_level_o
);
	import dvio_pkg::*;
	// Idle bus from time zero
	initial begin
		{wr_en_o, rd_en_o, iack_o} = 3'b000;
		{addr_o, wr_data_o, iack_level_o} = 35'h0_0000_0000;
	end
	task automatic cyc(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] d,
		input logic [2:0] l, output logic [15:0] q);
		@(posedge core_clk_i);
		{wr_en_o, rd_en_o, iack_o} <= kind;
		{addr_o, wr_data_o, iack_level_o} <= {a, d, l};
		@(posedge core_clk_i);
		// Released lines show the inverse so stale values never match
		{wr_en_o, rd_en_o, iack_o} <= 3'b000;
		{addr_o, wr_data_o, iack_level_o} <= ~{a, d, l};
		@(posedge core_clk_i);
		q = rd_data_i;
	endtask : cyc
endmodule : dvio_host

// ### tb/vme_digital_io_ports_tb.sv
// Self-checking bench for the digital I/O port block.
`timescale 1ns/1ps
module vme_digital_io_ports_tb;
	import dvio_pkg::*;
	localparam logic [5:0] BASE = 6'h2D;
	// Arbitrary identification text
	localparam logic [63:0] ID = 64'h5445_5354_4944_3031;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [15:0] addr, wdat, rdat, x, d;
	logic wr, rd, iack, irq;
	logic [2:0] ilvl, lvl, lsel;
	logic [7:0] esel, line, dir, vec, flag;
	logic [63:0] pin, pout, poe, lat, e;
	int seed = 32'ha401_c21c;
	int error_cnt = 0;
	int compares = 0;
	int k;
	always #20 core_clk_i = ~core_clk_i;
	dvio_top #(.ID_TEXT(ID)) uut (.core_clk_i, .resetn_i, .addr_i(addr), .wr_data_i(wdat),
		.wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdat), .iack_i(iack), .iack_level_i(ilvl),
		.base_sel_i(BASE), .irq_level_sel_i(lsel), .edge_sel_i(esel), .irq_line_i(line),
		.port_in_i(pin), .port_out_o(pout), .port_oe_o(poe), .flag_o(flag), .irq_o(irq),
		.irq_level_o(lvl));
	dvio_host host (.core_clk_i, .rd_data_i(rdat), .addr_o(addr), .wr_data_o(wdat),
		.wr_en_o(wr), .rd_en_o(rd), .iack_o(iack), .iack_level_o(ilvl));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input logic [9:0] o, input logic [15:0] v);
		host.cyc(3'b100, {BASE, o}, v, 3'h0, x);
	endtask : put
	task automatic get(input logic [9:0] o, input logic [15:0] v);
		host.cyc(3'b010, {BASE, o}, DATA_ZERO, 3'h0, x);
		chk(64'(x), 64'(v));
	endtask : get
	// Bounded wait for the request; running out counts as a mismatch
	task automatic wait_irq();
		for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge core_clk_i);
		if (k == 20) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, irq, 1'b1);
			results();
		end
	endtask : wait_irq
	function automatic logic [63:0] spread(input logic [7:0] s);
		for (int b = 0; b < 64; b++) spread[b] = s[b / 8];
	endfunction : spread
	task automatic results();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// Main sequence; edge select is static, so lines idle opposite to it
	initial begin
		esel = $random(seed);
		line = ~esel;
		lsel = 3'h5;
		pin = {$random(seed), $random(seed)};
		lat = PORT_RST;
		repeat (5) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		put(OFF_ID0, 16'hFFFF);
		for (k = 0; k < 4; k++) get(10'(OFF_ID0 + 2 * k), ID[63 - 16 * k -: 16]);
		host.cyc(3'b010, {~BASE, OFF_ID0}, DATA_ZERO, 3'h0, x);
		chk(64'(x), 64'(DATA_ZERO));
		repeat (4) begin
			dir = $random(seed);
			put(OFF_DIR, {8'h00, dir});
			for (k = 0; k < 4; k++) begin
				d = $random(seed);
				put(10'(OFF_PORT0 + 2 * k), d);
				lat[16 * k +: 16] = d;
			end
			chk(poe, spread(dir));
			chk(pout, lat);
			e = (lat & spread(dir)) | (pin & ~spread(dir));
			for (k = 0; k < 4; k++) get(10'(OFF_PORT0 + 2 * k), e[16 * k +: 16]);
			put(OFF_FLAG, d);
			chk(64'(flag), 64'(d[7:0]));
		end
		vec = $random(seed);
		put(OFF_VEC, {8'h00, vec});
		put(OFF_MASK, 16'h0000);
		put(OFF_CTRL, 16'h0001);
		// Good edge per line, then the wrong edge back
		for (int i = 0; i < 8; i++) begin
			line[i] <= esel[i];
			wait_irq();
			chk(64'(lvl), 64'h5);
			get(OFF_PEND, 16'(1 << i));
			host.cyc(3'b001, 16'h0000, DATA_ZERO, 3'h5, x);
			chk(64'(x), 64'(vec));
			line[i] <= ~esel[i];
			put(OFF_CLR, {8'h00, ~(8'h01 << i)});
			get(OFF_PEND, 16'(1 << i));
			put(OFF_CLR, 16'h00FF);
			get(OFF_PEND, DATA_ZERO);
			chk(64'(irq), 64'h0);
		end
		// Corners: raw lines, odd and read-only offsets, enable, level zero
		get(OFF_IRQIN, {8'h00, ~esel});
		get(OFF_CTRL, 16'h0001);
		get(10'(OFF_PORT0 + 1), DATA_ZERO);
		put(OFF_PEND, 16'h00FF);
		get(OFF_PEND, DATA_ZERO);
		line[1] <= esel[1];
		wait_irq();
		host.cyc(3'b001, 16'h0000, DATA_ZERO, 3'h2, x);
		chk(64'(x), 64'h0);
		put(OFF_CTRL, 16'h0000);
		chk(64'(irq), 64'h0);
		host.cyc(3'b001, 16'h0000, DATA_ZERO, 3'h5, x);
		chk(64'(x), 64'h0);
		put(OFF_CTRL, 16'h0001);
		chk(64'(irq), 64'h1);
		lsel <= 3'h0;
		repeat (5) @(posedge core_clk_i);
		chk(64'(irq), 64'h0);
		chk(64'(lvl), 64'h0);
		lsel <= 3'h5;
		repeat (5) @(posedge core_clk_i);
		chk(64'(irq), 64'h1);
		put(OFF_MASK, 16'h00FF);
		line[0] <= esel[0];
		repeat (8) @(posedge core_clk_i);
		chk(64'(irq), 64'h0);
		put(OFF_CTRL, 16'h0002);
		get(OFF_DIR, {8'h00, DIR_RST});
		get(OFF_MASK, {8'h00, MASK_RST});
		get(OFF_VEC, {8'h00, VEC_RST});
		chk(poe, PORT_RST);
		get(OFF_CTRL, DATA_ZERO);
		get(OFF_PEND, DATA_ZERO);
		chk(pout, PORT_RST);
		chk(64'(flag), 64'(FLAG_RST));
		results();
	end
endmodule : vme_digital_io_ports_tb
